// >>> rtl/trcd_defs.vh
`ifndef TRCD_DEFS_VH
`define TRCD_DEFS_VH
`define TRCD_NUM_IN 6
`define TRCD_FSEL_W 6
`define TRCD_FILT_W 10
`define TRCD_MODE_W 2
`define TRCD_FN_NONE 6'h00
`define TRCD_FN_FWD 6'h01
`define TRCD_FN_REV 6'h02
`define TRCD_FN_3WIRE 6'h03
`define TRCD_FN_JOGF 6'h04
`define TRCD_FN_JOGR 6'h05
`define TRCD_FN_UP 6'h06
`define TRCD_FN_DOWN 6'h07
`define TRCD_FN_COAST 6'h08
`define TRCD_FN_FRESET 6'h09
`define TRCD_FN_PAUSE 6'h0A
`define TRCD_FN_EXTFLT 6'h0B
`define TRCD_FN_SPD0 6'h0C
`define TRCD_FN_SPD1 6'h0D
`define TRCD_FN_SPD2 6'h0E
`define TRCD_FN_SPD3 6'h0F
`define TRCD_FN_ACC0 6'h10
`define TRCD_FN_ACC1 6'h11
`define TRCD_FN_SRCSW 6'h12
`define TRCD_FN_UDCLR 6'h13
`define TRCD_FSEL_DEF1 6'h00
`define TRCD_FSEL_DEF2 6'h04
`define TRCD_FSEL_DEF3 6'h09
`define TRCD_FSEL_DEF4 6'h0C
`define TRCD_FSEL_DEF5 6'h0D
`define TRCD_FSEL_DEF6 6'h00
`define TRCD_MODE_2W1 2'h0
`define TRCD_MODE_2W2 2'h1
`define TRCD_MODE_3W1 2'h2
`define TRCD_MODE_3W2 2'h3
`define TRCD_CLK_HZ 25000000
`define TRCD_FILT_UNIT_US 1000
`define TRCD_TICK_CYC ((`TRCD_CLK_HZ / 1000000) * `TRCD_FILT_UNIT_US)
`define TRCD_TICK_W 15
`define TRCD_TICK_LAST 15'h61A7
`define TRCD_FILT_DEF_MS 10'h00A
`define TRCD_FILT_MAX 10'h3E8
`define TRCD_FN_MAX 6'h31
`define TRCD_PULSE_IN 4
`endif

// >>> rtl/trcd_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "trcd_defs.vh"
module trcd_filter (
  input wire core_clk,
  input wire rst,
  input wire tick,
  input wire [`TRCD_FILT_W-1:0] filt_ms,
  input wire raw,
  output reg level_r
);
  reg [`TRCD_FILT_W-1:0] cnt_r;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      level_r <= 1'b0;
      cnt_r <= {`TRCD_FILT_W{1'b0}};
    end
    else if (raw == level_r)
      cnt_r <= {`TRCD_FILT_W{1'b0}};
    // (RQ16) stable for filter time
    // one extra tick, so a partial first ms never counts as a whole one
    else if (filt_ms == {`TRCD_FILT_W{1'b0}} || (tick && cnt_r >= filt_ms))
    begin
      level_r <= raw;
      cnt_r <= {`TRCD_FILT_W{1'b0}};
    end
    else if (tick)
      cnt_r <= cnt_r + 1'b1;
  end
endmodule
`default_nettype wire

// >>> rtl/trcd_decoder.v
// Contract
// (RQ1) five inputs, fifth also pulse capable; the code has six
// (RQ2) per-input selector 0..49, given defaults
// (RQ3) code zero does nothing
// (RQ4) codes 1,2 forward/backward run
// (RQ5) code 3 three-wire enable
// (RQ6) codes 4,5 jog forward/backward
// (RQ7) codes 6,7 up/down when digital source
// (RQ8) code 8 coast stop immediately
// (RQ9) code 9 fault reset
// (RQ10) code 10 pause, resume after release
// (RQ11) code 11 raises external fault
// (RQ12) codes 12..15 four-bit speed select
// (RQ13) codes 16,17 two-bit ramp select
// (RQ14) code 18 frequency source switchover
// (RQ15) code 19 clears up/down adjustment
// (RQ16) filter 0..1000 ms, default 10
// (RQ17) command method 0..3, default 0
// (RQ18) method 0: exclusive forward/backward
// (RQ19) method 1: enable plus direction
// (RQ20) method 2: enable, direction pulses start
// (RQ21) three-wire stops only on enable open
// (RQ22) configurer assigns code 3 for enable
// (RQ23) method 3: pulse starts, level direction
// (RQ24) latch run on edge, hold until enable
`timescale 1ns/1ps
`default_nettype none
`include "trcd_defs.vh"
module trcd_decoder (
  input wire core_clk,
  input wire rst,
  input wire [`TRCD_NUM_IN-1:0] multi_function_input,
  input wire [`TRCD_FSEL_W-1:0] input_one_function_select,
  input wire [`TRCD_FSEL_W-1:0] input_two_function_select,
  input wire [`TRCD_FSEL_W-1:0] input_three_function_select,
  input wire [`TRCD_FSEL_W-1:0] input_four_function_select,
  input wire [`TRCD_FSEL_W-1:0] input_five_function_select,
  input wire [`TRCD_FSEL_W-1:0] input_six_function_select,
  input wire sel_load,
  input wire [`TRCD_FILT_W-1:0] input_filter_time,
  input wire [`TRCD_MODE_W-1:0] command_method_select,
  input wire freq_src_digital,
  input wire freq_src_dual,
  output reg run_r,
  output reg dir_backward_r,
  output reg jog_forward_r,
  output reg jog_backward_r,
  output reg freq_up_r,
  output reg freq_down_r,
  output reg coast_stop_r,
  output reg fault_reset_r,
  output reg pause_r,
  output reg external_fault_code_r,
  output reg [3:0] speed_select_r,
  output reg [1:0] ramp_select_r,
  output reg freq_src_alt_r,
  output reg updown_clear_r,
  output reg pulse_capable_input_r,
  output reg [`TRCD_FILT_W-1:0] filter_time_r,
  output reg [`TRCD_MODE_W-1:0] method_r
);
  reg [`TRCD_FSEL_W*`TRCD_NUM_IN-1:0] fsel_r;
  reg [`TRCD_TICK_W-1:0] tick_cnt_r;
  reg tick_r;
  reg latch_r;
  reg latch_dir_r;
  reg fwd_d_r;
  reg rev_d_r;
  wire [`TRCD_NUM_IN-1:0] filt;
  wire [`TRCD_FSEL_W*`TRCD_NUM_IN-1:0] fsel_in;
  wire [`TRCD_FSEL_W*`TRCD_NUM_IN-1:0] fsel_ok;
  genvar g;
  assign fsel_in = {input_six_function_select, input_five_function_select,
    input_four_function_select, input_three_function_select,
    input_two_function_select, input_one_function_select};

  // (RQ2) codes above 49 are stored as no function
  generate
    for (g = 0; g < `TRCD_NUM_IN; g = g + 1)
    begin : g_fsel
      assign fsel_ok[g*`TRCD_FSEL_W +: `TRCD_FSEL_W] =
        (fsel_in[g*`TRCD_FSEL_W +: `TRCD_FSEL_W] > `TRCD_FN_MAX) ?
        `TRCD_FN_NONE : fsel_in[g*`TRCD_FSEL_W +: `TRCD_FSEL_W];
    end
  endgenerate

  // true if any filtered input carries function code fn
  // several terminals on one code are ored together
  function any_fn;
    input [`TRCD_FSEL_W*`TRCD_NUM_IN-1:0] sel;
    input [`TRCD_NUM_IN-1:0] lv;
    input [`TRCD_FSEL_W-1:0] fn;
    integer i;
    begin
      any_fn = 1'b0;
      for (i = 0; i < `TRCD_NUM_IN; i = i + 1)
        if (lv[i] && sel[i*`TRCD_FSEL_W +: `TRCD_FSEL_W] == fn)
          any_fn = 1'b1;
    end
  endfunction

  // methods 2 and 3 both run from the latched request
  function three_wire;
    input [`TRCD_MODE_W-1:0] m;
    begin
      three_wire = (m == `TRCD_MODE_3W1) || (m == `TRCD_MODE_3W2);
    end
  endfunction

  // settings move only on sel_load
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      // (RQ2) reset defaults
      fsel_r <= {`TRCD_FSEL_DEF6, `TRCD_FSEL_DEF5, `TRCD_FSEL_DEF4,
        `TRCD_FSEL_DEF3, `TRCD_FSEL_DEF2, `TRCD_FSEL_DEF1};
      // (RQ16) default filter time
      filter_time_r <= `TRCD_FILT_DEF_MS;
      // (RQ17) default command method
      method_r <= `TRCD_MODE_2W1;
    end
    else if (sel_load)
    begin
      fsel_r <= fsel_ok;
      // out of range filter value clamps to max
      filter_time_r <= (input_filter_time > `TRCD_FILT_MAX) ? `TRCD_FILT_MAX : input_filter_time;
      method_r <= command_method_select;
    end
  end

  // millisecond tick for filter counting
  // one shared divider keeps the six filters in step
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_r <= {`TRCD_TICK_W{1'b0}};
      tick_r <= 1'b0;
    end
    else if (tick_cnt_r == `TRCD_TICK_LAST)
    begin
      tick_cnt_r <= {`TRCD_TICK_W{1'b0}};
      tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // (RQ1) one filter per terminal
  generate
    for (g = 0; g < `TRCD_NUM_IN; g = g + 1)
    begin : g_filt
      trcd_filter u_filt (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick_r),
        .filt_ms(filter_time_r),
        .raw(multi_function_input[g]),
        .level_r(filt[g])
      );
    end
  endgenerate

  wire fwd_in = any_fn(fsel_r, filt, `TRCD_FN_FWD);
  wire rev_in = any_fn(fsel_r, filt, `TRCD_FN_REV);
  // (RQ5) three-wire enable terminal
  wire en3 = any_fn(fsel_r, filt, `TRCD_FN_3WIRE);
  wire fwd_rise = fwd_in & ~fwd_d_r;
  wire rev_rise = rev_in & ~rev_d_r;

  // three-wire run latch
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      latch_r <= 1'b0;
      latch_dir_r <= 1'b0;
      fwd_d_r <= 1'b0;
      rev_d_r <= 1'b0;
    end
    else
    begin
      fwd_d_r <= fwd_in;
      rev_d_r <= rev_in;
      // (RQ21) stop only on enable open
      // leaving the three-wire methods also drops the latch
      if (!en3 || !three_wire(method_r))
        latch_r <= 1'b0;
      // (RQ20) direction pulses start
      // forward wins when both pulses land together
      else if (method_r == `TRCD_MODE_3W1 && (fwd_rise || rev_rise))
      begin
        latch_r <= 1'b1;
        latch_dir_r <= ~fwd_rise;
      end
      // (RQ24) latch on filtered edge
      else if (method_r == `TRCD_MODE_3W2 && fwd_rise)
        latch_r <= 1'b1;
    end
  end

  // run decoding per command method
  reg run_nxt;
  reg dir_nxt;
  always @*
  begin
    run_nxt = 1'b0;
    dir_nxt = 1'b0;
    case (method_r)
      // (RQ18) exclusive two-wire
      `TRCD_MODE_2W1:
      begin
        run_nxt = fwd_in ^ rev_in;
        dir_nxt = rev_in & ~fwd_in;
      end
      // (RQ19) enable plus direction
      `TRCD_MODE_2W2:
      begin
        run_nxt = fwd_in;
        dir_nxt = fwd_in & rev_in;
      end
      `TRCD_MODE_3W1:
      begin
        run_nxt = latch_r;
        dir_nxt = latch_dir_r;
      end
      // (RQ23) level selects direction
      `TRCD_MODE_3W2:
      begin
        run_nxt = latch_r;
        dir_nxt = rev_in;
      end
      default:
      begin
        run_nxt = 1'b0;
        dir_nxt = 1'b0;
      end
    endcase
  end

  // (RQ3) code zero never matched below
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      run_r <= 1'b0;
      dir_backward_r <= 1'b0;
      jog_forward_r <= 1'b0;
      jog_backward_r <= 1'b0;
      freq_up_r <= 1'b0;
      freq_down_r <= 1'b0;
      coast_stop_r <= 1'b0;
      fault_reset_r <= 1'b0;
      pause_r <= 1'b0;
      external_fault_code_r <= 1'b0;
      speed_select_r <= 4'h0;
      ramp_select_r <= 2'h0;
      freq_src_alt_r <= 1'b0;
      updown_clear_r <= 1'b0;
      pulse_capable_input_r <= 1'b0;
    end
    else
    begin
      // (RQ4) run and direction
      run_r <= run_nxt;
      dir_backward_r <= dir_nxt;
      // (RQ6) jog while active
      jog_forward_r <= any_fn(fsel_r, filt, `TRCD_FN_JOGF);
      jog_backward_r <= any_fn(fsel_r, filt, `TRCD_FN_JOGR);
      // (RQ7) only with digital source
      freq_up_r <= freq_src_digital & any_fn(fsel_r, filt, `TRCD_FN_UP);
      freq_down_r <= freq_src_digital & any_fn(fsel_r, filt, `TRCD_FN_DOWN);
      // (RQ8) coast stop level
      coast_stop_r <= any_fn(fsel_r, filt, `TRCD_FN_COAST);
      // (RQ9) fault reset level
      fault_reset_r <= any_fn(fsel_r, filt, `TRCD_FN_FRESET);
      // (RQ10) pause while held; run state kept upstream
      pause_r <= any_fn(fsel_r, filt, `TRCD_FN_PAUSE);
      // (RQ11) external fault raise
      external_fault_code_r <= any_fn(fsel_r, filt, `TRCD_FN_EXTFLT);
      // (RQ12) four-bit speed select
      speed_select_r <= {any_fn(fsel_r, filt, `TRCD_FN_SPD3),
        any_fn(fsel_r, filt, `TRCD_FN_SPD2),
        any_fn(fsel_r, filt, `TRCD_FN_SPD1),
        any_fn(fsel_r, filt, `TRCD_FN_SPD0)};
      // (RQ13) two-bit ramp select
      ramp_select_r <= {any_fn(fsel_r, filt, `TRCD_FN_ACC1),
        any_fn(fsel_r, filt, `TRCD_FN_ACC0)};
      // (RQ14) switchover in dual mode
      freq_src_alt_r <= freq_src_dual & any_fn(fsel_r, filt, `TRCD_FN_SRCSW);
      // (RQ15) up/down clear
      updown_clear_r <= any_fn(fsel_r, filt, `TRCD_FN_UDCLR);
      // raw copy for pulse counting, no filter delay
      pulse_capable_input_r <= multi_function_input[`TRCD_PULSE_IN];
    end
  end
endmodule
`default_nettype wire

// >>> test/trcd_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module trcd_switch_model (
  input wire logic [5:0] contact_closed,
  output logic [5:0] terminal_level
);
  // contacts to terminals
  // bounce left to the bench, which makes its own glitches
  assign terminal_level = contact_closed;
endmodule
`default_nettype wire

// >>> test/trcd_props.sv
`timescale 1ns/1ps
`default_nettype none
module trcd_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] multi_function_input,
  input wire logic sel_load,
  input wire logic [9:0] input_filter_time,
  input wire logic [1:0] command_method_select,
  input wire logic freq_src_digital,
  input wire logic run_r,
  input wire logic freq_up_r,
  input wire logic freq_down_r,
  input wire logic pulse_capable_input_r,
  input wire logic [9:0] filter_time_r,
  input wire logic [1:0] method_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // gate may sit one stage before the output register
  sequence s_no_digital;
    !freq_src_digital [*3];
  endsequence
  a_reset_settings: assert property ($fell(rst) |->
    filter_time_r == 10'h00A && method_r == 2'h0)
    else $error("settings not at defaults after reset");
  a_reset_quiet: assert property ($fell(rst) |->
    !run_r && !freq_up_r && !pulse_capable_input_r)
    else $error("outputs active after reset");
  a_load_method: assert property (sel_load |=> method_r == $past(command_method_select))
    else $error("method not captured");
  a_load_filter: assert property (sel_load && input_filter_time <= 10'h3E8 |=>
    filter_time_r == $past(input_filter_time))
    else $error("filter time not captured");
  a_filter_clamp: assert property (sel_load && input_filter_time > 10'h3E8 |=>
    filter_time_r == 10'h3E8)
    else $error("filter time not clamped");
  a_settings_hold: assert property (!sel_load |=>
    $stable(method_r) && $stable(filter_time_r))
    else $error("settings changed without load");
  a_pulse_follow: assert property (!$past(rst) |->
    pulse_capable_input_r == $past(multi_function_input[4]))
    else $error("pulse input copy wrong");
  a_updown_gate: assert property (s_no_digital |-> !freq_up_r && !freq_down_r)
    else $error("up/down active without digital source");
endmodule
bind trcd_decoder trcd_props u_trcd_props (.core_clk(core_clk), .rst(rst),
  .multi_function_input(multi_function_input), .sel_load(sel_load),
  .input_filter_time(input_filter_time), .command_method_select(command_method_select),
  .freq_src_digital(freq_src_digital), .run_r(run_r), .freq_up_r(freq_up_r),
  .freq_down_r(freq_down_r), .pulse_capable_input_r(pulse_capable_input_r),
  .filter_time_r(filter_time_r), .method_r(method_r));
`default_nettype wire

// >>> test/terminal_run_command_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module terminal_run_command_decoder_tb_top;
  logic core_clk = 0;
  logic rst = 1;
  logic [5:0] sw = 0;
  logic [5:0] fs [0:5];
  logic sel_load = 0;
  logic [9:0] ft = 0;
  logic [1:0] cm = 0;
  logic dig = 1;
  logic dual = 1;
  int fails = 0;
  int compares = 0;
  wire [5:0] term;
  wire run_r, dir_r, jf, jb, up, dn, co, fr, pa, ef, alt, udc, pci;
  wire [3:0] spd;
  wire [1:0] rmp;
  wire [9:0] filter_time_r;
  wire [1:0] method_r;
  wire [15:0] fvec = {udc, alt, rmp, spd, ef, pa, fr, co, dn, up, jb, jf};
  wire [15:0] rd = {14'h0000, run_r, run_r & dir_r};
  always #20 core_clk = ~core_clk;
  trcd_switch_model u_trcd_switch_model (.contact_closed(sw), .terminal_level(term));
  trcd_decoder u_trcd_decoder (.core_clk(core_clk), .rst(rst), .multi_function_input(term),
    .input_one_function_select(fs[0]), .input_two_function_select(fs[1]),
    .input_three_function_select(fs[2]), .input_four_function_select(fs[3]),
    .input_five_function_select(fs[4]), .input_six_function_select(fs[5]),
    .sel_load(sel_load), .input_filter_time(ft), .command_method_select(cm),
    .freq_src_digital(dig), .freq_src_dual(dual), .run_r(run_r), .dir_backward_r(dir_r),
    .jog_forward_r(jf), .jog_backward_r(jb), .freq_up_r(up), .freq_down_r(dn),
    .coast_stop_r(co), .fault_reset_r(fr), .pause_r(pa), .external_fault_code_r(ef),
    .speed_select_r(spd), .ramp_select_r(rmp), .freq_src_alt_r(alt), .updown_clear_r(udc),
    .pulse_capable_input_r(pci), .filter_time_r(filter_time_r), .method_r(method_r));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // terminal 2 backward, 3 enable, 4 no function, 6 an unused code
  task automatic cfg(input logic [5:0] c1, input logic [9:0] f, input logic [1:0] m);
    @(negedge core_clk);
    fs[0] = c1;
    fs[1] = 6'h02;
    fs[2] = 6'h03;
    fs[3] = 6'h00;
    fs[4] = 6'h00;
    fs[5] = 6'h14;
    ft = f;
    cm = m;
    sel_load = 1;
    @(negedge core_clk);
    sel_load = 0;
  endtask
  task automatic put(input logic [5:0] v, input int n);
    @(negedge core_clk);
    sw = v;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic final_report();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    foreach (fs[i]) fs[i] = 6'h00;
    repeat (20) @(negedge core_clk);
    rst = 0;
    @(negedge core_clk);
    chk(16'(filter_time_r), 16'h000A);
    chk(16'(method_r), 16'h0000);
    for (int m = 0; m < 2; m++)
    begin
      cfg(6'h01, 10'h000, 2'(m));
      for (int k = 0; k < 4; k++)
      begin
        put(6'(k), 3);
        chk(rd, 16'(((m == 1 ? 8'hC8 : 8'h38) >> (2 * k)) & 8'h03));
      end
    end
    cfg(6'h01, 10'h000, 2'h2);
    put(6'h01, 3);
    chk(rd, 16'h0000);
    put(6'h04, 3);
    put(6'h05, 3);
    put(6'h04, 3);
    chk(rd, 16'h0002);
    put(6'h00, 3);
    chk(rd, 16'h0000);
    put(6'h04, 3);
    put(6'h06, 3);
    put(6'h04, 3);
    chk(rd, 16'h0003);
    put(6'h00, 3);
    cfg(6'h01, 10'h000, 2'h3);
    put(6'h06, 3);
    put(6'h07, 3);
    put(6'h06, 3);
    chk(rd, 16'h0003);
    put(6'h04, 3);
    chk(rd, 16'h0002);
    put(6'h00, 3);
    chk(rd, 16'h0000);
    for (int c = 4; c < 20; c++)
    begin
      cfg(6'(c), 10'h000, 2'h0);
      put(6'h29, 3);
      chk(fvec, 16'h0001 << (c - 4));
      chk(rd, 16'h0000);
      put(6'h00, 3);
      chk(fvec, 16'h0000);
    end
    for (int i = 0; i < 2; i++)
    begin
      cfg(i == 1 ? 6'h12 : 6'h06, 10'h000, 2'h0);
      dig = 0;
      dual = 0;
      put(6'h01, 3);
      chk(fvec, 16'h0000);
      put(6'h00, 3);
      dig = 1;
      dual = 1;
    end
    put(6'h10, 1);
    chk(16'(pci), 16'h0001);
    put(6'h00, 1);
    chk(16'(pci), 16'h0000);
    // a level held under the filter time must never pass, whatever the tick phase
    cfg(6'h01, 10'h001, 2'h0);
    put(6'h01, 20000);
    chk(rd, 16'h0000);
    put(6'h00, 3);
    put(6'h01, 24990);
    chk(rd, 16'h0000);
    put(6'h01, 25020);
    chk(rd, 16'h0002);
    cfg(6'h01, 10'h3FF, 2'h0);
    chk(16'(filter_time_r), 16'h03E8);
    final_report();
  end
  initial
  begin
    repeat (100000) @(posedge core_clk);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
